// *** bench/cpm_chipset.sv ***
// Chipset model driving the stop and power-down pins.
// Assumes the bench asks for pin levels; pins follow on a falling edge.
`timescale 1ns/100ps
`default_nettype none
module cpm_chipset (
  input  wire logic       clk_i,
  input  wire logic [2:0] req_i,
  input  wire logic [3:0] lag_i,
  output logic [2:0]      pins_o
);
  logic [3:0] wait_reg;
  initial begin
    pins_o = 3'h7;
    wait_reg = 4'h0;
  end
  // Lag models a slow chipset; a level is never pulsed
  always @(negedge clk_i) begin
    if (req_i == pins_o)
      wait_reg <= lag_i;
    else if (wait_reg != 4'h0)
      wait_reg <= wait_reg - 4'h1;
    else
      pins_o <= req_i;
  end
endmodule
`default_nettype wire

// *** bench/cpm_properties.sv ***
// Checker for the clock output power management block.
// Assumes configuration inputs stay still while a stop is held.
`timescale 1ns/100ps
`default_nettype none
module cpm_properties #(
  parameter int N_CPU = 3, N_PCI = 7, N_PCI_FREE_CLK_OUT = 3, N_66 = 5, N_48 = 2,
  parameter int WAKE_CYCLES = 20
) (
  input wire logic              clk_i,
  input wire logic              rst_b_i,
  input wire logic              ce_i,
  input wire logic              power_down_n_i,
  input wire logic              cpu_stop_n_i,
  input wire logic              pci_stop_n_i,
  input wire logic              tristate_sel_a_i,
  input wire logic              tristate_sel_b_i,
  input wire logic              pci_stop_bit_i,
  input wire logic [N_CPU-1:0]  cpu_stoppable_i,
  input wire logic [N_PCI_FREE_CLK_OUT-1:0] pci_free_run_i,
  input wire logic [N_CPU-1:0]  cpu_clk_true_o,
  input wire logic [N_CPU-1:0]  cpu_clk_comp_o,
  input wire logic [N_CPU-1:0]  cpu_true_oe_o,
  input wire logic [N_CPU-1:0]  cpu_comp_oe_o,
  input wire logic [2*N_CPU-1:0] cpu_drive_o,
  input wire logic [N_PCI-1:0]  pci_clk_o,
  input wire logic [N_PCI_FREE_CLK_OUT-1:0] pci_free_clk_out_o,
  input wire logic              buffered_66m_clk_o,
  input wire logic [N_66-1:0]   clk66_out_o,
  input wire logic [N_48-1:0]   clk48m_a_o,
  input wire logic              pci_stop_bit_rd_o,
  input wire logic              pll_enable_o
);
  logic [7:0] lo_reg, up_reg, cs_reg, ps_reg, ok_reg;
  logic       run, off, any;
  function automatic logic [7:0] sat(input logic [7:0] c, input logic clr);
    return clr ? 8'h00 : c + {7'h00, c != 8'hFF};
  endfunction
  // Long holds only, so sync latency never matters
  always_ff @(posedge clk_i) begin
    lo_reg <= sat(lo_reg, !rst_b_i || power_down_n_i);
    up_reg <= sat(up_reg, !rst_b_i || !power_down_n_i);
    cs_reg <= sat(cs_reg, !rst_b_i || cpu_stop_n_i || !power_down_n_i);
    ps_reg <= sat(ps_reg, !rst_b_i || !power_down_n_i
                  || (pci_stop_n_i && pci_stop_bit_i));
    ok_reg <= sat(ok_reg, !rst_b_i || !ce_i || !(cpu_stop_n_i && pci_stop_n_i
                  && pci_stop_bit_i && power_down_n_i));
  end
  assign run = up_reg > 8'(WAKE_CYCLES + 40);
  assign off = lo_reg > 8'h46;
  assign any = |{pci_clk_o, pci_free_clk_out_o, buffered_66m_clk_o,
                 clk66_out_o, clk48m_a_o};
  default clocking @(posedge clk_i); endclocking
  // A frozen block stretches every phase, so checks pause with it
  default disable iff (!rst_b_i || !ce_i);
  pll_after_stop_a: assert property ($fell(pll_enable_o) |-> !any)
    else $error("PLL off while a clock still runs");
  pd_all_low_a: assert property (off |-> !pll_enable_o && !any)
    else $error("Clock or PLL alive in power down");
  pd_drive_a: assert property (
    off && !tristate_sel_a_i && !tristate_sel_b_i
    |-> &cpu_clk_true_o && &cpu_true_oe_o && !(|cpu_comp_oe_o)
    && cpu_drive_o == {N_CPU{cpm_pkg::DRV_X2}})
    else $error("CPU pair drive wrong in power down");
  pd_hiz_a: assert property (
    off && (tristate_sel_a_i || tristate_sel_b_i)
    |-> !(|{cpu_true_oe_o, cpu_comp_oe_o}))
    else $error("CPU pair driven in power down");
  cpu_stop_a: assert property (
    run && cs_reg > 8'h14 && cpu_stoppable_i[0]
    |-> cpu_clk_true_o[0] && !cpu_clk_comp_o[0]
    && cpu_true_oe_o[0] == !tristate_sel_b_i
    && (tristate_sel_b_i || cpu_drive_o[1:0] == cpm_pkg::DRV_X6))
    else $error("Stopped CPU pair in wrong state");
  pci_held_a: assert property (
    run && ps_reg > 8'h18 |-> !(|pci_clk_o)
    && !(|(pci_free_clk_out_o & ~pci_free_run_i)) && !pci_stop_bit_rd_o)
    else $error("PCI clock running while stopped");
  cpu_resume_a: assert property (
    run && ok_reg > 8'h10
    |-> cpu_clk_true_o == ~$past(cpu_clk_true_o)
    && cpu_clk_comp_o == ~cpu_clk_true_o && cpu_drive_o == '0)
    else $error("CPU pair not running after stop release");
  wake_pll_a: assert property (up_reg > 8'(WAKE_CYCLES) |-> pll_enable_o)
    else $error("PLL still off after wake time");
  pci_runt_a: assert property (
    $rose(pci_clk_o[0])
    |=> pci_clk_o[0] [*3] ##1 !pci_clk_o[0])
    else $error("PCI high phase cut short");
  buf_runt_a: assert property (
    $rose(buffered_66m_clk_o)
    |=> buffered_66m_clk_o ##1 !buffered_66m_clk_o)
    else $error("Buffered 66 high phase cut short");
  cover property (off);
  cover property (run && cs_reg > 8'h14 && tristate_sel_b_i);
  cover property (run && ps_reg > 8'h18);
endmodule
bind cpm_top cpm_properties #(.N_CPU(N_CPU), .N_PCI(N_PCI), .N_PCI_FREE_CLK_OUT(N_PCI_FREE_CLK_OUT),
  .N_66(N_66), .N_48(N_48), .WAKE_CYCLES(WAKE_CYCLES)) prop_u (.*);
`default_nettype wire

// *** bench/cpm_tb.sv ***
// Self-checking bench for the clock output power management block.
// Assumes the chipset model and checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module cpm_tb;
  localparam int WK = 60;
  logic        clk_i = 0, rst_b_i = 0, sel_a = 0, sel_b = 0, bit_i = 1;
  logic [2:0]  req = 3'h7, pins, stp = 3'h0, frn = 3'h0;
  logic [3:0]  lag = 4'h0;
  logic        ce = 1;
  logic [2:0]  ct, cc, toe, coe, pcf;
  logic [5:0]  drv;
  logic [6:0]  pci;
  logic [4:0]  c66;
  logic [1:0]  c48;
  logic        b66, rd, pll;
  int          bad_count = 0, tests_run = 0, cyc = 0, tf, tb, tp;
  cpm_chipset cs_u (.clk_i(clk_i), .req_i(req), .lag_i(lag), .pins_o(pins));
  cpm_top #(.WAKE_CYCLES(WK)) dut_u (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce),
    .power_down_n_i(pins[2]), .cpu_stop_n_i(pins[1]), .pci_stop_n_i(pins[0]),
    .tristate_sel_a_i(sel_a), .tristate_sel_b_i(sel_b),
    .pci_stop_bit_i(bit_i), .cpu_stoppable_i(stp), .pci_free_run_i(frn),
    .cpu_clk_true_o(ct), .cpu_clk_comp_o(cc), .cpu_true_oe_o(toe),
    .cpu_comp_oe_o(coe), .cpu_drive_o(drv), .pci_clk_o(pci),
    .pci_free_clk_out_o(pcf), .buffered_66m_clk_o(b66), .clk66_out_o(c66),
    .clk48m_a_o(c48), .pci_stop_bit_rd_o(rd), .pll_enable_o(pll));
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Hang guard; the run needs under 2000 cycles
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      test_done();
    end
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // Bits set for outputs seen both high and low over one PCI period
  task automatic tog(output logic [20:0] t);
    logic [20:0] h, l;
    h = '0;
    l = '0;
    repeat (8) begin
      @(negedge clk_i);
      h |= {ct, pci, pcf, b66, c66, c48};
      l |= ~{ct, pci, pcf, b66, c66, c48};
    end
    t = h & l;
  endtask
  initial begin
    logic [20:0] t;
    logic [23:0] snap;
    void'($urandom(84855));
    wt(8);
    rst_b_i = 1;
    wt(120);
    tog(t);
    chk(t, 21'h1FFFFF);
    chk({rd, pll}, 2'h3);
    // Enable low must freeze every clock output mid-phase
    ce = 0;
    snap = {ct, cc, pci, pcf, b66, c66, c48};
    wt(6);
    chk({ct, cc, pci, pcf, b66, c66, c48}, snap);
    ce = 1;
    for (int m = 0; m < 4; m++) begin
      {sel_a, sel_b} = m[1:0];
      stp = 3'($urandom);
      frn = 3'($urandom);
      lag = 4'($urandom);
      req = 3'h5;
      wt(40);
      tog(t);
      chk(t[20:18], 3'(~stp));
      chk({ct & stp, cc & stp}, {stp, 3'h0});
      chk(toe & stp, sel_b ? 3'h0 : stp);
      chk(drv[1:0], (stp[0] && !sel_b) ? cpm_pkg::DRV_X6
                                       : cpm_pkg::DRV_NORMAL);
      req = 3'h7;
      wt(30);
      tog(t);
      chk(t[20:18], 3'h7);
      if (m[0])
        req = 3'h6;
      else
        bit_i = 0;
      wt(30);
      tog(t);
      chk(t, {3'h7, 7'h0, frn, 8'hFF});
      chk(rd, 1'b0);
      req = 3'h7;
      bit_i = 1;
      wt(22);
      tog(t);
      chk(t, 21'h1FFFFF);
      req = 3'h3;
      tf = 0;
      tb = 0;
      tp = 0;
      for (int i = 1; i < 80; i++) begin
        @(negedge clk_i);
        if (|pcf) tf = i;
        if (b66) tb = i;
        if (|pci) tp = i;
      end
      chk({tb > tf, tp > tb}, 2'h3);
      chk({pll, pci, pcf, b66, c66, c48}, 32'h0);
      chk({toe, coe}, m == 0 ? 6'h38 : 6'h00);
      chk(drv, m == 0 ? {3{cpm_pkg::DRV_X2}} : 6'h00);
      req = 3'h7;
      wt(WK + 30);
      tog(t);
      chk({pll, t}, 22'h3FFFFF);
    end
    test_done();
  end
endmodule
`default_nettype wire

// *** core/cpm_gate.sv ***
// Glitch-free stop cell for one output clock.
// Assumes src_i is a registered clock level on the same clk.
`timescale 1ns/100ps
`default_nettype none
module cpm_gate (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic ce_i,
  input  wire logic src_i,
  input  wire logic stop_i,
  output logic      out_o,
  output logic      stopped_o
);
  logic src_prev_reg;
  logic run_reg;
  logic fall;
  logic run_next;

  assign fall     = src_prev_reg & ~src_i;
  // Run state only moves at a falling edge: no runt high phase
  assign run_next = fall ? ~stop_i : run_reg;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      src_prev_reg <= 1'b0;
      run_reg      <= 1'b1;
      out_o        <= 1'b0;
    end else if (ce_i) begin
      src_prev_reg <= src_i;
      run_reg      <= run_next;
      out_o        <= src_i & run_next;
    end
  end

  assign stopped_o = ~run_reg;
endmodule
`default_nettype wire

// *** core/cpm_pkg.sv ***
// Constants shared by the clock output power management block.
// Assumes a single 10 MHz system clock drives all logic.
package cpm_pkg;
  localparam int          CLK_PERIOD_NS   = 100;
  localparam int          WAKE_MAX_NS     = 1800000;
  // Strictly less than the limit, so one cycle is taken off
  localparam int          WAKE_CYCLES     = WAKE_MAX_NS / CLK_PERIOD_NS - 1;
  localparam int          PD_EDGE_COUNT   = 2;
  localparam int          STOP_EDGE_COUNT = 2;
  localparam logic [1:0]  DRV_NORMAL      = 2'h0;
  localparam logic [1:0]  DRV_X6          = 2'h1;
  localparam logic [1:0]  DRV_X2          = 2'h2;
  localparam logic [2:0]  PHASE_RESET     = 3'h0;
  localparam int          PHASE_CPU_BIT   = 0;
  localparam int          PHASE_66_BIT    = 1;
  localparam int          PHASE_PCI_BIT   = 2;

  typedef enum logic [2:0] {
    PD_RUN,
    PD_STOP_PCI_FREE_CLK_OUT,
    PD_STOP_B66,
    PD_STOP_REST,
    PD_PLL_OFF,
    PD_WAKE
  } cpm_pd_state_type;
endpackage

// *** core/cpm_top.sv ***
// Top of the clock output power management block.
// Assumes chipset pins are asynchronous; config bits come from clk logic.
`timescale 1ns/100ps
`default_nettype none
module cpm_top #(
  parameter int N_CPU       = 3,
  parameter int N_PCI       = 7,
  parameter int N_PCI_FREE_CLK_OUT      = 3,
  parameter int N_66        = 5,
  parameter int N_48        = 2,
  parameter int WAKE_CYCLES = cpm_pkg::WAKE_CYCLES
) (
  input  wire logic               clk_i,
  input  wire logic               rst_b_i,
  input  wire logic               ce_i,
  input  wire logic               power_down_n_i,
  input  wire logic               cpu_stop_n_i,
  input  wire logic               pci_stop_n_i,
  input  wire logic               tristate_sel_a_i,
  input  wire logic               tristate_sel_b_i,
  input  wire logic               pci_stop_bit_i,
  input  wire logic [N_CPU-1:0]   cpu_stoppable_i,
  input  wire logic [N_PCI_FREE_CLK_OUT-1:0]  pci_free_run_i,
  output logic [N_CPU-1:0]        cpu_clk_true_o,
  output logic [N_CPU-1:0]        cpu_clk_comp_o,
  output logic [N_CPU-1:0]        cpu_true_oe_o,
  output logic [N_CPU-1:0]        cpu_comp_oe_o,
  output logic [2*N_CPU-1:0]      cpu_drive_o,
  output logic [N_PCI-1:0]        pci_clk_o,
  output logic [N_PCI_FREE_CLK_OUT-1:0]       pci_free_clk_out_o,
  output logic                    buffered_66m_clk_o,
  output logic [N_66-1:0]         clk66_out_o,
  output logic [N_48-1:0]         clk48m_a_o,
  output logic                    pci_stop_bit_rd_o,
  output logic                    pll_enable_o
);
  localparam int NG = N_CPU + N_PCI + N_PCI_FREE_CLK_OUT + 1 + N_66 + N_48;

  cpm_pkg::cpm_pd_state_type pd_state_reg;
  logic [2:0]  sync1_reg;
  logic [2:0]  sync2_reg;
  logic [2:0]  sync3_reg;
  logic [2:0]  pin_reg;
  logic [2:0]  phase_reg;
  logic        cpu_prev_reg;
  logic [1:0]  pd_cnt_reg;
  logic [1:0]  stp_cnt_reg;
  logic        pd_seen_reg;
  logic        cpu_stop_act_reg;
  logic [31:0] wake_cnt_reg;
  logic        cpu_fall;
  logic        pci_stop_eff;
  logic [NG-1:0] src;
  logic [NG-1:0] stop;
  logic [NG-1:0] gate_out;
  logic [NG-1:0] gate_stopped;
  logic        rest_stop;
  logic        pd_lock;

  // Three-flop sampling of the asynchronous pins, order {pd, cpu, pci}
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sync1_reg <= 3'h7;
      sync2_reg <= 3'h7;
      sync3_reg <= 3'h7;
      pin_reg   <= 3'h7;
    end else if (ce_i) begin
      sync1_reg <= {power_down_n_i, cpu_stop_n_i, pci_stop_n_i};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      for (int i = 0; i < 3; i++) begin
        if (sync2_reg[i] == sync3_reg[i]) begin
          pin_reg[i] <= sync3_reg[i];
        end
      end
    end
  end

  // Stand-in for the PLL: phase counter held at PHASE_RESET while the PLL is off
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      phase_reg    <= cpm_pkg::PHASE_RESET;
      cpu_prev_reg <= 1'b0;
    end else if (ce_i) begin
      if (pd_state_reg == cpm_pkg::PD_PLL_OFF) begin
        phase_reg <= cpm_pkg::PHASE_RESET;
      end else begin
        phase_reg <= phase_reg + 3'h1;
      end
      cpu_prev_reg <= phase_reg[cpm_pkg::PHASE_CPU_BIT];
    end
  end

  // True falls exactly when the complement rises
  assign cpu_fall = cpu_prev_reg & ~phase_reg[cpm_pkg::PHASE_CPU_BIT];

  // Power-down recognition and CPU stop edge qualification
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pd_cnt_reg       <= 2'h0;
      stp_cnt_reg      <= 2'h0;
      pd_seen_reg      <= 1'b0;
      cpu_stop_act_reg <= 1'b0;
    end else if (ce_i) begin
      if (pin_reg[2]) begin
        pd_cnt_reg  <= 2'h0;
        pd_seen_reg <= 1'b0;
      end else if (cpu_fall && !pd_seen_reg) begin
        if (pd_cnt_reg == 2'(cpm_pkg::PD_EDGE_COUNT - 1)) begin
          pd_seen_reg <= 1'b1;
        end
        pd_cnt_reg <= pd_cnt_reg + 2'h1;
      end
      if (pin_reg[1]) begin
        stp_cnt_reg      <= 2'h0;
        cpu_stop_act_reg <= 1'b0;
      end else if (cpu_fall && !cpu_stop_act_reg) begin
        if (stp_cnt_reg == 2'(cpm_pkg::STOP_EDGE_COUNT - 1)) begin
          cpu_stop_act_reg <= 1'b1;
        end
        stp_cnt_reg <= stp_cnt_reg + 2'h1;
      end
    end
  end

  // Power-down sequencer: each stage waits for the previous to settle
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pd_state_reg <= cpm_pkg::PD_RUN;
      wake_cnt_reg <= 32'h0;
    end else if (ce_i) begin
      case (pd_state_reg)
        cpm_pkg::PD_RUN: begin
          if (pd_seen_reg) begin
            pd_state_reg <= cpm_pkg::PD_STOP_PCI_FREE_CLK_OUT;
          end
        end
        cpm_pkg::PD_STOP_PCI_FREE_CLK_OUT: begin
          if (&gate_stopped[N_CPU+N_PCI +: N_PCI_FREE_CLK_OUT]) begin
            pd_state_reg <= cpm_pkg::PD_STOP_B66;
          end
        end
        cpm_pkg::PD_STOP_B66: begin
          if (gate_stopped[N_CPU+N_PCI+N_PCI_FREE_CLK_OUT]) begin
            pd_state_reg <= cpm_pkg::PD_STOP_REST;
          end
        end
        cpm_pkg::PD_STOP_REST: begin
          if (&gate_stopped) begin
            pd_state_reg <= cpm_pkg::PD_PLL_OFF;
          end
        end
        cpm_pkg::PD_PLL_OFF: begin
          wake_cnt_reg <= 32'h0;
          if (pin_reg[2]) begin
            pd_state_reg <= cpm_pkg::PD_WAKE;
          end
        end
        cpm_pkg::PD_WAKE: begin
          // Release well inside the limit; settle time is the budget less 7 cycles
          if (wake_cnt_reg >= 32'(WAKE_CYCLES - 8)) begin
            pd_state_reg <= cpm_pkg::PD_RUN;
          end
          wake_cnt_reg <= wake_cnt_reg + 32'h1;
        end
        default: begin
          pd_state_reg <= cpm_pkg::PD_RUN;
        end
      endcase
    end
  end

  assign pd_lock      = pd_state_reg != cpm_pkg::PD_RUN;
  assign rest_stop    = pd_lock && pd_state_reg != cpm_pkg::PD_STOP_PCI_FREE_CLK_OUT
                        && pd_state_reg != cpm_pkg::PD_STOP_B66;
  assign pci_stop_eff = ~(pin_reg[0] & pci_stop_bit_i);

  // Gate sources and stop requests, one slot per output clock
  always_comb begin
    src  = '0;
    stop = '0;
    for (int i = 0; i < N_CPU; i++) begin
      src[i]  = ~phase_reg[cpm_pkg::PHASE_CPU_BIT];
      stop[i] = (cpu_stop_act_reg & cpu_stoppable_i[i]) | rest_stop;
    end
    for (int i = 0; i < N_PCI; i++) begin
      src[N_CPU+i]  = phase_reg[cpm_pkg::PHASE_PCI_BIT];
      stop[N_CPU+i] = pci_stop_eff | rest_stop;
    end
    for (int i = 0; i < N_PCI_FREE_CLK_OUT; i++) begin
      src[N_CPU+N_PCI+i]  = phase_reg[cpm_pkg::PHASE_PCI_BIT];
      stop[N_CPU+N_PCI+i] = (pci_stop_eff & ~pci_free_run_i[i]) | pd_lock;
    end
    src[N_CPU+N_PCI+N_PCI_FREE_CLK_OUT]  = phase_reg[cpm_pkg::PHASE_66_BIT];
    stop[N_CPU+N_PCI+N_PCI_FREE_CLK_OUT] = pd_lock && pd_state_reg != cpm_pkg::PD_STOP_PCI_FREE_CLK_OUT;
    for (int i = N_CPU + N_PCI + N_PCI_FREE_CLK_OUT + 1; i < NG; i++) begin
      src[i]  = phase_reg[cpm_pkg::PHASE_66_BIT];
      stop[i] = rest_stop;
    end
  end

  // Restart only at a falling edge keeps every pulse full width
  for (genvar g = 0; g < NG; g++) begin : g_gate
    cpm_gate u_gate (
      .clk_i     (clk_i),
      .rst_b_i   (rst_b_i),
      .ce_i      (ce_i),
      .src_i     (src[g]),
      .stop_i    (stop[g]),
      .out_o     (gate_out[g]),
      .stopped_o (gate_stopped[g])
    );
  end

  // CPU pair levels, enables and drive strength
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cpu_clk_true_o <= '0;
      cpu_clk_comp_o <= '0;
      cpu_true_oe_o  <= '1;
      cpu_comp_oe_o  <= '1;
      cpu_drive_o    <= '0;
    end else if (ce_i) begin
      for (int i = 0; i < N_CPU; i++) begin
        cpu_clk_comp_o[i]    <= gate_out[i];
        cpu_clk_true_o[i]    <= ~gate_out[i];
        cpu_true_oe_o[i]     <= 1'b1;
        cpu_comp_oe_o[i]     <= 1'b1;
        cpu_drive_o[2*i +: 2] <= cpm_pkg::DRV_NORMAL;
        if (pd_lock && gate_stopped[i]) begin
          cpu_clk_comp_o[i] <= 1'b0;
          cpu_comp_oe_o[i]  <= 1'b0;
          if (tristate_sel_a_i | tristate_sel_b_i) begin
            cpu_true_oe_o[i] <= 1'b0;
          end else begin
            cpu_drive_o[2*i +: 2] <= cpm_pkg::DRV_X2;
          end
        end else if (cpu_stop_act_reg && gate_stopped[i]) begin
          if (tristate_sel_b_i) begin
            cpu_true_oe_o[i] <= 1'b0;
            cpu_comp_oe_o[i] <= 1'b0;
          end else begin
            cpu_drive_o[2*i +: 2] <= cpm_pkg::DRV_X6;
          end
        end
      end
    end
  end

  // Remaining clock outputs, read-back and PLL enable
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pci_clk_o          <= '0;
      pci_free_clk_out_o <= '0;
      buffered_66m_clk_o <= 1'b0;
      clk66_out_o        <= '0;
      clk48m_a_o         <= '0;
      pci_stop_bit_rd_o  <= 1'b1;
      pll_enable_o       <= 1'b1;
    end else if (ce_i) begin
      pci_clk_o          <= gate_out[N_CPU +: N_PCI];
      pci_free_clk_out_o <= gate_out[N_CPU+N_PCI +: N_PCI_FREE_CLK_OUT];
      buffered_66m_clk_o <= gate_out[N_CPU+N_PCI+N_PCI_FREE_CLK_OUT];
      clk66_out_o        <= gate_out[N_CPU+N_PCI+N_PCI_FREE_CLK_OUT+1 +: N_66];
      clk48m_a_o         <= gate_out[NG-N_48 +: N_48];
      pci_stop_bit_rd_o  <= pin_reg[0] & pci_stop_bit_i;
      pll_enable_o       <= pd_state_reg != cpm_pkg::PD_PLL_OFF;
    end
  end
endmodule
`default_nettype wire
